// ### hw/flash_seq_pkg.sv
// Constants and types shared by the flash program/erase sequencer
package flash_seq_pkg;
	// Device command codes
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_WORD_WRITE = 8'h40;
	localparam logic [7:0] CMD_BUF_SETUP = 8'he8;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	// Status word bit positions
	localparam int ENGINE_READY_BIT = 7;
	localparam int ERASE_FAIL_BIT = 5;
	localparam int PROGRAM_FAIL_BIT = 4;
	localparam int SUPPLY_FAULT_BIT = 3;
	localparam int PROTECT_REFUSE_BIT = 1;
	localparam int BUFFER_AVAIL_BIT = 7;
	// Software register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_BUF = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RESULT = 8'h14;
	// Control word fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_DEFER_BIT = 4;
	// Reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// Bus phase timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_PHASE_NS = 100;
	localparam int PHASE_CYCLES_RAW = (T_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHASE_CYCLES = (PHASE_CYCLES_RAW < 1) ? 1 : PHASE_CYCLES_RAW;
	localparam logic [1:0] PHASE_LAST = 2'h3;

	// Operations software can order
	typedef enum logic [3:0] {
		OP_CHIP_ERASE,
		OP_BLOCK_ERASE,
		OP_WORD_WRITE,
		OP_BUF_WRITE,
		OP_LOCK_SET,
		OP_CLEAR_STATUS,
		OP_READ_ARRAY,
		OP_CHECK
	} op_t;

	// Outcome of a full status check
	typedef enum logic [3:0] {
		ERR_NONE,
		ERR_SUPPLY,
		ERR_PROTECT,
		ERR_SEQUENCE,
		ERR_ERASE,
		ERR_PROGRAM
	} err_t;

	// One bus cycle toward the device
	typedef struct packed {
		logic is_read;
		logic [31:0] addr;
		logic [15:0] data;
	} bus_cycle_t;
endpackage : flash_seq_pkg

// ### hw/flash_program_erase_sequencer.sv
// Host-side sequencer driving a clockless parallel flash for program and erase
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_sequencer #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16,
	parameter int BUF_DEPTH = 16,
	parameter int BLOCK_AW = 15
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Software register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Flash pins
	output logic [ADDR_W-1:0] flash_addr_out,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_n_out,
	output logic flash_ce_n_out,
	output logic flash_we_n_out,
	output logic flash_oe_n_out
);
	localparam int IDX_W = $clog2(BUF_DEPTH + 1);

	typedef enum logic [3:0] {
		S_IDLE, S_PRE_CMD, S_PRE_RD, S_OP_CMD1, S_OP_CMD2, S_BUF_XSR, S_BUF_CNT,
		S_BUF_DAT, S_POLL_RD, S_CHECK, S_ARR_FF, S_ARR_RD, S_CLR
	} state_t;

	// Full status check in documented priority order
	function automatic flash_seq_pkg::err_t classify(input logic [7:0] sw);
		if (sw[flash_seq_pkg::SUPPLY_FAULT_BIT])
			return flash_seq_pkg::ERR_SUPPLY;
		if (sw[flash_seq_pkg::PROTECT_REFUSE_BIT])
			return flash_seq_pkg::ERR_PROTECT;
		if (sw[flash_seq_pkg::ERASE_FAIL_BIT] && sw[flash_seq_pkg::PROGRAM_FAIL_BIT])
			return flash_seq_pkg::ERR_SEQUENCE;
		if (sw[flash_seq_pkg::ERASE_FAIL_BIT])
			return flash_seq_pkg::ERR_ERASE;
		if (sw[flash_seq_pkg::PROGRAM_FAIL_BIT])
			return flash_seq_pkg::ERR_PROGRAM;
		return flash_seq_pkg::ERR_NONE;
	endfunction : classify

	state_t state_reg, state_next;
	flash_seq_pkg::op_t op_reg;
	flash_seq_pkg::err_t err_reg;
	flash_seq_pkg::bus_cycle_t cyc;
	logic [7:0] div_reg;
	logic [1:0] ph_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
	logic [IDX_W-1:0] buf_cnt_reg;
	logic [IDX_W-1:0] buf_idx_reg;
	logic [DATA_W-1:0] sample_reg;
	logic [7:0] status_word_reg;
	logic [DATA_W-1:0] result_reg;
	logic defer_reg;
	logic err_pending_reg;
	logic refused_reg;
	logic unaligned_reg;

	// Phase divider and bus cycle progress
	wire tick = (div_reg == 8'(flash_seq_pkg::PHASE_CYCLES - 1));
	wire bus_state = (state_reg != S_IDLE) && (state_reg != S_CHECK);
	wire cyc_done = bus_state && tick && (ph_reg == flash_seq_pkg::PHASE_LAST);
	wire sample_now = bus_state && cyc.is_read && tick && (ph_reg == 2'h2);
	wire strobe_ph = (ph_reg == 2'h1) || (ph_reg == 2'h2);
	// ready taken from bit 7 of the word read
	wire ready = sample_reg[flash_seq_pkg::ENGINE_READY_BIT];
	// only bit 7 of buffer status is looked at
	wire buf_avail = sample_reg[flash_seq_pkg::BUFFER_AVAIL_BIT];

	// Register port decode
	wire wr_ctrl = reg_wr_in && (reg_addr_in == flash_seq_pkg::REG_CTRL);
	wire wr_buf = reg_wr_in && (reg_addr_in == flash_seq_pkg::REG_BUF);
	wire [3:0] new_op = reg_wdata_in[flash_seq_pkg::CTRL_OP_LSB +: 4];
	wire new_is_clear = (new_op == 4'(flash_seq_pkg::OP_CLEAR_STATUS));
	wire op_known = (new_op <= 4'(flash_seq_pkg::OP_CHECK));
	// after a check reports an error only clear-status is accepted
	wire blocked = err_pending_reg && !new_is_clear;
	wire start = wr_ctrl && (state_reg == S_IDLE) && op_known && !blocked;
	wire refuse = wr_ctrl && !start;
	// start off a buffer boundary is flagged
	wire misalign = (op_reg == flash_seq_pkg::OP_BUF_WRITE) &&
		(addr_reg[$clog2(BUF_DEPTH)-1:0] != '0);
	// host sends at most one buffered word past the start block, then stops
	wire [ADDR_W-1:0] buf_addr = addr_reg + ADDR_W'(buf_idx_reg);
	wire in_block = (buf_addr[ADDR_W-1:BLOCK_AW] == addr_reg[ADDR_W-1:BLOCK_AW]);
	wire [IDX_W-1:0] cnt_eff = (buf_cnt_reg == '0) ? IDX_W'(1) : buf_cnt_reg;
	wire last_dat = (buf_idx_reg == cnt_eff - IDX_W'(1)) || !in_block;

	wire [31:0] status_rd = {8'h00, 8'(buf_cnt_reg), status_word_reg, err_reg,
		unaligned_reg, refused_reg, err_pending_reg, (state_reg != S_IDLE)};
	wire [31:0] rd_word =
		(reg_addr_in == flash_seq_pkg::REG_CTRL) ? {27'h0, defer_reg, 4'(op_reg)} :
		(reg_addr_in == flash_seq_pkg::REG_ADDR) ? 32'(addr_reg) :
		(reg_addr_in == flash_seq_pkg::REG_DATA) ? 32'(data_reg) :
		(reg_addr_in == flash_seq_pkg::REG_STATUS) ? status_rd :
		(reg_addr_in == flash_seq_pkg::REG_RESULT) ? 32'(result_reg) : 32'h0000_0000;

	// Bus cycle of the present state
	always_comb begin
		cyc = '0;
		cyc.addr = 32'(addr_reg);
		unique case (state_reg)
			S_PRE_CMD: cyc.data = 16'(flash_seq_pkg::CMD_READ_STATUS);
			S_PRE_RD, S_POLL_RD, S_BUF_XSR, S_ARR_RD: cyc.is_read = 1'b1;
			S_OP_CMD1: begin
				unique case (op_reg)
					flash_seq_pkg::OP_CHIP_ERASE: cyc.data = 16'(flash_seq_pkg::CMD_CHIP_ERASE);
					flash_seq_pkg::OP_BLOCK_ERASE: cyc.data = 16'(flash_seq_pkg::CMD_BLOCK_ERASE);
					flash_seq_pkg::OP_WORD_WRITE: cyc.data = 16'(flash_seq_pkg::CMD_WORD_WRITE);
					flash_seq_pkg::OP_BUF_WRITE: cyc.data = 16'(flash_seq_pkg::CMD_BUF_SETUP);
					default: cyc.data = 16'(flash_seq_pkg::CMD_LOCK_SETUP);
				endcase
			end
			S_OP_CMD2: begin
				if (op_reg == flash_seq_pkg::OP_WORD_WRITE)
					cyc.data = 16'(data_reg);
				else if (op_reg == flash_seq_pkg::OP_LOCK_SET)
					cyc.data = 16'(flash_seq_pkg::CMD_LOCK_CONFIRM);
				else
					cyc.data = 16'(flash_seq_pkg::CMD_CONFIRM);
			end
			// count minus one on low lines
			S_BUF_CNT: cyc.data = {8'h00, 8'(cnt_eff - IDX_W'(1))};
			// data from the start address upward
			S_BUF_DAT: begin
				cyc.addr = 32'(buf_addr);
				cyc.data = 16'(buf_mem[buf_idx_reg[$clog2(BUF_DEPTH)-1:0]]);
			end
			S_ARR_FF: cyc.data = 16'(flash_seq_pkg::CMD_READ_ARRAY);
			S_CLR: cyc.data = 16'(flash_seq_pkg::CMD_CLEAR_STATUS);
			default: cyc.data = 16'h0000;
		endcase
	end

	// Sequence of bus cycles per operation
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: if (start) state_next = S_PRE_CMD;
			S_PRE_CMD: if (cyc_done) state_next = S_PRE_RD;
			S_PRE_RD: begin
				if (cyc_done) begin
					// wait for ready before any new command
					if (!ready)
						state_next = S_PRE_CMD;
					else if (op_reg == flash_seq_pkg::OP_CLEAR_STATUS)
						state_next = S_CLR;
					else if (op_reg == flash_seq_pkg::OP_READ_ARRAY)
						state_next = S_ARR_FF;
					else if (op_reg == flash_seq_pkg::OP_CHECK)
						state_next = S_CHECK;
					else
						state_next = S_OP_CMD1;
				end
			end
			S_OP_CMD1: begin
				if (cyc_done)
					state_next = (op_reg == flash_seq_pkg::OP_BUF_WRITE) ? S_BUF_XSR : S_OP_CMD2;
			end
			S_BUF_XSR: if (cyc_done) state_next = buf_avail ? S_BUF_CNT : S_OP_CMD1;
			S_BUF_CNT: if (cyc_done) state_next = S_BUF_DAT;
			S_BUF_DAT: if (cyc_done && last_dat) state_next = S_OP_CMD2;
			S_OP_CMD2: if (cyc_done) state_next = S_POLL_RD;
			// reads now return status while busy
			S_POLL_RD: begin
				if (cyc_done && ready)
					state_next = defer_reg ? S_IDLE : S_CHECK;
			end
			S_CHECK: state_next = S_IDLE;
			S_ARR_FF: if (cyc_done) state_next = S_ARR_RD;
			S_ARR_RD, S_CLR: if (cyc_done) state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	// Divider and phase counter
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || tick)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
		if (reset_in || !bus_state || state_next != state_reg)
			ph_reg <= 2'h0;
		else if (tick)
			ph_reg <= ph_reg + 2'h1;
	end

	// Pin drivers, registered; strobes low in phases 1 and 2
	always_ff @(posedge sys_clk_in) begin
		flash_ce_n_out <= reset_in || !bus_state;
		flash_we_n_out <= reset_in || !(bus_state && !cyc.is_read && strobe_ph);
		flash_oe_n_out <= reset_in || !(bus_state && cyc.is_read && strobe_ph);
		flash_dq_oe_n_out <= reset_in || !(bus_state && !cyc.is_read);
		flash_addr_out <= reset_in ? '0 : cyc.addr[ADDR_W-1:0];
		flash_dq_out <= reset_in ? '0 : cyc.data[DATA_W-1:0];
	end

	// Main state and read sample
	always_ff @(posedge sys_clk_in) begin
		state_reg <= reset_in ? S_IDLE : state_next;
		if (reset_in)
			sample_reg <= '0;
		else if (sample_now)
			sample_reg <= flash_dq_in;
	end

	// Buffer index walks the data items
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || state_reg != S_BUF_DAT)
			buf_idx_reg <= '0;
		else if (cyc_done)
			buf_idx_reg <= buf_idx_reg + IDX_W'(1);
	end

	// Software writes; buffer pushes stop when full
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			addr_reg <= '0;
			data_reg <= '0;
			buf_cnt_reg <= '0;
			defer_reg <= 1'b0;
			op_reg <= flash_seq_pkg::OP_CHIP_ERASE;
		end else begin
			if (reg_wr_in && reg_addr_in == flash_seq_pkg::REG_ADDR)
				addr_reg <= reg_wdata_in[ADDR_W-1:0];
			if (reg_wr_in && reg_addr_in == flash_seq_pkg::REG_DATA)
				data_reg <= reg_wdata_in[DATA_W-1:0];
			if (start) begin
				op_reg <= flash_seq_pkg::op_t'(new_op);
				defer_reg <= reg_wdata_in[flash_seq_pkg::CTRL_DEFER_BIT];
			end
			if (start && new_op == 4'(flash_seq_pkg::OP_BUF_WRITE))
				buf_cnt_reg <= buf_cnt_reg;
			else if (state_reg == S_OP_CMD2 && cyc_done)
				buf_cnt_reg <= '0;
			else if (wr_buf && buf_cnt_reg < IDX_W'(BUF_DEPTH))
				buf_cnt_reg <= buf_cnt_reg + IDX_W'(1);
		end
	end

	// Buffer storage, flip-flops addressed by count
	always_ff @(posedge sys_clk_in) begin
		for (int i = 0; i < BUF_DEPTH; i++) begin
			if (wr_buf && buf_cnt_reg == IDX_W'(i))
				buf_mem[i] <= reg_wdata_in[DATA_W-1:0];
		end
	end

	// Status and result capture
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			status_word_reg <= 8'h00;
			result_reg <= '0;
			err_reg <= flash_seq_pkg::ERR_NONE;
			err_pending_reg <= 1'b0;
			refused_reg <= 1'b0;
			unaligned_reg <= 1'b0;
		end else begin
			if (cyc_done && (state_reg == S_PRE_RD || state_reg == S_POLL_RD))
				status_word_reg <= sample_reg[7:0];
			if (cyc_done && state_reg == S_ARR_RD)
				result_reg <= sample_reg;
			else if (cyc_done && state_reg == S_BUF_XSR)
				result_reg <= {{(DATA_W-1){1'b0}}, buf_avail};
			// device keeps bits, one check sees them all
			// deferred check through the check order
			// aborted buffer shows as sequence error
			if (state_reg == S_CHECK) begin
				err_reg <= classify(status_word_reg);
				err_pending_reg <= (classify(status_word_reg) != flash_seq_pkg::ERR_NONE);
			end else if (state_reg == S_CLR && cyc_done) begin
				err_reg <= flash_seq_pkg::ERR_NONE;
				err_pending_reg <= 1'b0;
			end
			if (refuse)
				refused_reg <= 1'b1;
			else if (start)
				refused_reg <= 1'b0;
			if (state_reg == S_OP_CMD1)
				unaligned_reg <= misalign;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || !reg_rd_in)
			reg_rdata_out <= flash_seq_pkg::RESET_WORD;
		else
			reg_rdata_out <= rd_word;
	end
endmodule : flash_program_erase_sequencer
`default_nettype wire

// ### verif/flash_seq_assertions.sv
// Pin timing and register read checks of the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_seq_assertions #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	// Clock, reset and register reads
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// Flash pins
	input wire logic [ADDR_W-1:0] flash_addr_out,
	input wire logic [DATA_W-1:0] flash_dq_out,
	input wire logic flash_dq_oe_n_out,
	input wire logic flash_ce_n_out,
	input wire logic flash_we_n_out,
	input wire logic flash_oe_n_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	// Strobes only inside a chip-enable window
	a_write_in_select: assert property (!flash_we_n_out |-> !flash_ce_n_out)
		else $error("write strobe without chip enable");
	a_read_in_select: assert property (!flash_oe_n_out |-> !flash_ce_n_out && flash_we_n_out)
		else $error("read strobe without select or during write");
	// Sequencer lets go of the lines while the device may drive them
	a_no_contention: assert property (!flash_oe_n_out |-> flash_dq_oe_n_out)
		else $error("data lines driven during a read");
	a_write_driven: assert property (!flash_we_n_out |-> !flash_dq_oe_n_out)
		else $error("write strobe with undriven data lines");
	// Each strobe is low for two clocks
	a_write_width: assert property ($fell(flash_we_n_out) |=> !flash_we_n_out ##1 flash_we_n_out)
		else $error("write strobe width wrong");
	a_read_width: assert property ($fell(flash_oe_n_out) |=> !flash_oe_n_out ##1 flash_oe_n_out)
		else $error("read strobe width wrong");
	// Address and data settle a clock before the device latches them
	a_write_stable: assert property (!flash_we_n_out |-> $stable(flash_addr_out) && $stable(flash_dq_out))
		else $error("address or data moved under write strobe");
	// Read data stand only in the cycle after the strobe
	a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
	// Pins idle through reset, so no stray command reaches the device
	a_reset_idle: assert property (disable iff (1'b0) reset_in |=> flash_ce_n_out && flash_we_n_out
		&& flash_oe_n_out && flash_dq_oe_n_out) else $error("flash pins active after reset");
endmodule : flash_seq_assertions
bind flash_program_erase_sequencer flash_seq_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
	.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
	.flash_dq_oe_n_out(flash_dq_oe_n_out), .flash_ce_n_out(flash_ce_n_out),
	.flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out));
`default_nettype wire

// ### verif/flash_dev_model.sv
// Behavioural model of the clockless parallel flash
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model (
	// Bus strobes
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	// Address and data
	input wire logic [19:0] addr_in,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	// Fault injection and engine run length in status reads
	input wire logic [7:0] fail_in,
	input wire logic [3:0] busy_len_in
);
	logic [15:0] mem [int];
	logic [6:0] err = 7'h00;
	logic [7:0] setup = 8'h00;
	logic [15:0] rd_val = 16'h0000;
	int busy = 0;
	int mode = 0;
	int left = -1;
	int xwait = 0;
	// Released lines show the inverse, never a stale value
	assign dq_out = (!ce_n_in && !oe_n_in) ? rd_val : ~rd_val;
	task automatic start_op();
		busy = busy_len_in;
		err = err | fail_in[6:0];
		setup = 8'h00;
	endtask : start_op
	// bad sequence sets both fail bits
	task automatic seq_err();
		err[5:4] = 2'h3;
		setup = 8'h00;
	endtask : seq_err
	always @(posedge we_n_in) begin
		if (!ce_n_in) begin
			mode = 1;
			if (setup == flash_seq_pkg::CMD_WORD_WRITE || setup == 8'h10) begin
				mem[int'(addr_in)] = dq_in;
				start_op();
			end else if (setup == flash_seq_pkg::CMD_BUF_SETUP) begin
				if (left < 0 && dq_in[7:0] == flash_seq_pkg::CMD_BUF_SETUP) mode = 2;
				else if (left < 0) left = int'(dq_in[7:0]) + 1;
				else if (left > 0) begin
					mem[int'(addr_in)] = dq_in;
					left--;
				end else if (dq_in[7:0] == flash_seq_pkg::CMD_CONFIRM) start_op();
				else seq_err();
			end else if (setup != 8'h00) begin
				if (dq_in[7:0] == ((setup == flash_seq_pkg::CMD_LOCK_SETUP) ?
					flash_seq_pkg::CMD_LOCK_CONFIRM : flash_seq_pkg::CMD_CONFIRM)) start_op();
				else seq_err();
			end else begin
				case (dq_in[7:0])
					flash_seq_pkg::CMD_READ_ARRAY: mode = 0;
					flash_seq_pkg::CMD_CLEAR_STATUS: err = 7'h00;
					flash_seq_pkg::CMD_READ_STATUS: setup = 8'h00;
					flash_seq_pkg::CMD_BUF_SETUP: begin
						setup = dq_in[7:0];
						left = -1;
						xwait = 1;
						mode = 2;
					end
					default: setup = dq_in[7:0];
				endcase
			end
		end
	end
	// array, status or buffer word; reserved bits carry junk
	always @(negedge oe_n_in) begin
		if (!ce_n_in && mode == 0) rd_val = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 16'hffff;
		else if (!ce_n_in && mode == 2) rd_val = {8'h00, xwait == 0, 7'h5a};
		else if (!ce_n_in) rd_val = {8'h00, busy == 0, err};
	end
	// Engine and buffer progress are counted in reads
	always @(posedge oe_n_in) begin
		if (busy > 0 && mode == 1) busy--;
		if (xwait > 0 && mode == 2) xwait--;
	end
endmodule : flash_dev_model
`default_nettype wire

// ### verif/flash_program_erase_sequencer_tb.sv
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_sequencer_tb;
	logic sys_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] rdata;
	logic [19:0] f_addr;
	logic [15:0] f_dq, dq_wire, dev_dq, wd;
	logic f_oe_dq_n, f_ce_n, f_we_n, f_oe_n;
	logic [7:0] fail = 8'h00;
	logic [3:0] busy_len = 4'h2;
	logic [63:0] exp_q[$];
	logic [63:0] n;
	logic [31:0] last_rd = 32'h0;
	logic [31:0] seed = 32'h3ccf9c2b;
	logic [15:0] bd [3];
	logic rd_seen = 1'b0;
	logic [7:0] fl [5] = '{8'h08, 8'h02, 8'h30, 8'h20, 8'h10};
	logic [4:0] ops [5] = '{5'h04, 5'h02, 5'h00, 5'h01, 5'h02};
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	flash_program_erase_sequencer uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .flash_addr_out(f_addr),
		.flash_dq_in(dq_wire), .flash_dq_out(f_dq), .flash_dq_oe_n_out(f_oe_dq_n),
		.flash_ce_n_out(f_ce_n), .flash_we_n_out(f_we_n), .flash_oe_n_out(f_oe_n));
	flash_dev_model dev (.ce_n_in(f_ce_n), .we_n_in(f_we_n), .oe_n_in(f_oe_n), .addr_in(f_addr),
		.dq_in(dq_wire), .dq_out(dev_dq), .fail_in(fail), .busy_len_in(busy_len));
	// Driven by the sequencer when enabled, else the device
	assign dq_wire = f_oe_dq_n ? dev_dq : f_dq;
	initial begin
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run();
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	// Mask and expectation queued; a zero mask only records the value
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back({m, e});
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge sys_clk_in);
		#1;
	endtask : rd
	task automatic run(input logic [4:0] ctl, input logic [31:0] m, input logic [31:0] e);
		wr(flash_seq_pkg::REG_CTRL, {27'h0, ctl});
		for (int i = 0; i < 300 && (i == 0 || last_rd[0] !== 1'b0); i++)
			rd(flash_seq_pkg::REG_STATUS, 32'h0, 32'h0);
		rd(flash_seq_pkg::REG_STATUS, m, e);
	endtask : run
	// Read data are looked at in the one cycle they stand
	always @(posedge sys_clk_in) rd_seen <= reg_rd_in;
	always @(negedge sys_clk_in) begin
		if (rd_seen) begin
			n = exp_q.pop_front();
			last_rd = rdata;
			if (n[63:32] != 32'h0) chk(rdata & n[63:32], n[31:0]);
		end
	end
	// Hang guard, far above the thousand or so cycles needed
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		rd(flash_seq_pkg::REG_STATUS, 32'hffffffff, 32'h0);
		rd(8'h3c, 32'hffffffff, 32'h0);
		seed = lfsr(seed);
		wd = seed[15:0];
		wr(flash_seq_pkg::REG_ADDR, 32'h00123);
		wr(flash_seq_pkg::REG_DATA, {16'h0, wd});
		run(5'h02, 32'hfff3, 32'h8000);
		chk({16'h0, dev.mem[32'h123]}, {16'h0, wd});
		run(5'h06, 32'h1, 32'h0);
		rd(flash_seq_pkg::REG_RESULT, 32'hffff, {16'h0, wd});
		// Each fault kind once, refused while pending, then cleared
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			busy_len <= seed[3:0];
			fail <= fl[i];
			run(ops[i], 32'hfff3, {16'h0, 8'h80 | fl[i], 4'(i + 1), 4'h2});
			fail <= 8'h00;
			wr(flash_seq_pkg::REG_CTRL, 32'h0);
			rd(flash_seq_pkg::REG_STATUS, 32'h6, 32'h6);
			run(5'h05, 32'h7, 32'h0);
		end
		// Deferred checks accumulate faults for one later check
		fail <= 8'h20;
		run(5'h11, 32'h1, 32'h0);
		fail <= 8'h00;
		run(5'h11, 32'h1, 32'h0);
		run(5'h07, 32'hfff3, 32'ha042);
		run(5'h05, 32'h7, 32'h0);
		wr(flash_seq_pkg::REG_ADDR, 32'h00200);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			bd[i] = seed[15:0];
			wr(flash_seq_pkg::REG_BUF, {16'h0, bd[i]});
		end
		rd(flash_seq_pkg::REG_STATUS, 32'hff0000, 32'h030000);
		run(5'h03, 32'hffff, 32'h8000);
		rd(flash_seq_pkg::REG_RESULT, 32'hffff, 32'h1);
		for (int i = 0; i < 3; i++)
			chk({16'h0, dev.mem[32'h200 + i]}, {16'h0, bd[i]});
		// Off-boundary start is flagged but still programmed
		wr(flash_seq_pkg::REG_ADDR, 32'h00201);
		seed = lfsr(seed);
		wr(flash_seq_pkg::REG_BUF, {16'h0, seed[15:0]});
		run(5'h03, 32'hffff, 32'h8008);
		chk({16'h0, dev.mem[32'h201]}, {16'h0, seed[15:0]});
		complete_run();
	end
endmodule : flash_program_erase_sequencer_tb
`default_nettype wire
